// *** hdl/isw_irq_wdt.sv ***
// interrupt sources, timer zero, shared scaler and watchdog
// assumes one clock, synchronous inputs, classic wishbone master
//
// Design decision made here: the Wishbone slave port.
`include "isw_defs.svh"

// Contract
// (R1) external pin edge: rising when polarity bit 1, falling when 0
// (R2) a valid external edge sets ext_edge_flag, control bit 1
// (R3) ext_irq_enable, control bit 4, gates the external request
// (R4) software clears ext_edge_flag; hardware never clears it
// (R5) external edge wakes from sleep only if enabled before sleep
// (R6) after wake-up, vector only with global enable, else in line
// (R7) timer zero rolling from ff to 00 sets its overflow flag, bit 2
// (R8) timer_zero_irq_enable, bit 5, gates the overflow request
// (R9) any level change on port b upper nibble sets bit 0
// (R10) port_change_irq_enable, bit 3, gates the port-change request
// (R11) taking an interrupt pushes only the return pc
// (R12) watchdog runs from rc oscillator, forced on while enabled
// (R13) unscaled watchdog period is nominally 16 ms
// (R14) time-out while running gives a full device reset
// (R15) time-out while asleep wakes the core, no reset
// (R16) every time-out clears watchdog_expiry_flag
// (R17) fuse bit at 0 disables the watchdog permanently; cfg_q stays bus-writable here, so a later cfg write re-enables it
// (R18) one scaler serves timer zero or watchdog per option bit
// (R19) clear and sleep reset watchdog and its assigned postscaler
// (R20) clear keeps the scaler assignment, only clears the count
// (R21) vectored wake-up loads the pc with the fixed vector
// (R22) flags set regardless of enables; enables gate requests only
module isw_irq_wdt #(
  parameter int RC_DIV    = `ISW_CLK_HZ / `ISW_RC_HZ,
  parameter int WDT_TICKS = `ISW_WDT_MS * `ISW_RC_HZ / 1000
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [15:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        ext_irq_pin_i,
  input  wire logic [3:0]  port_b_hi_i,
  input  wire logic        t0_pin_i,
  input  wire logic        clr_wdt_i,
  input  wire logic        sleep_i,
  input  wire logic [12:0] ret_pc_i,
  output logic             irq_req_o,
  output logic             push_o,
  output logic      [12:0] push_pc_o,
  output logic             pc_load_o,
  output logic      [12:0] pc_vec_o,
  output logic             wake_o,
  output logic             wdt_rst_o,
  output logic             rc_osc_en_o
);

  localparam int RW = $clog2(RC_DIV + 1);
  localparam int TW = $clog2(WDT_TICKS + 1);

  logic [7:0]       icr_q;
  logic [7:0]       icr_d;
  logic [7:0]       opt_q;
  logic [7:0]       cfg_q;
  logic [7:0]       tmr_q;
  logic [7:0]       scl_q;
  logic [7:0]       rd_d;
  logic [3:0]       pb_q;
  logic [RW-1:0]    rc_q;
  logic [TW-1:0]    wdt_q;
  logic             ext_q;
  logic             t0p_q;
  logic             ext_irq_enable_slp_q;
  logic             to_q;
  isw_pkg::isw_pwr_t pwr_q;

  // bus decode
  logic [13:0] idx;
  logic        acc;
  logic        wr;
  logic        wr_icr;
  logic        wr_opt;
  logic        wr_cfg;
  logic        wr_tmr;
  assign idx    = wb_adr_i[15:2];
  assign acc    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr     = acc & wb_we_i & wb_sel_i[0];
  assign wr_icr = wr & (idx == `ISW_IDX_ICR);
  assign wr_opt = wr & (idx == `ISW_IDX_OPT);
  assign wr_cfg = wr & (idx == `ISW_IDX_CFG);
  assign wr_tmr = wr & (idx == `ISW_IDX_TMR);

  always_comb begin
    case (idx)
      `ISW_IDX_ICR:  rd_d = icr_q;
      `ISW_IDX_OPT:  rd_d = opt_q;
      `ISW_IDX_CFG:  rd_d = cfg_q;
      `ISW_IDX_TMR:  rd_d = tmr_q;
      `ISW_IDX_STAT: rd_d = {3'h0, to_q, pwr_q == isw_pkg::ISW_SLEEP,
                             3'h0};
      default:       rd_d = 8'h00;
    endcase
  end

  // one wait state, ack dropped in the following cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= acc;
      if (acc & ~wb_we_i) begin
        wb_dat_o <= {24'h00_0000, rd_d};
      end
    end
  end

  // event detection
  logic ext_ev;
  logic pb_ev;
  logic t0_ev;
  logic t0_rise;
  logic t0_fall;
  assign ext_ev  = opt_q[`ISW_OPT_EDGE] ? (ext_irq_pin_i & ~ext_q)
                                        : (~ext_irq_pin_i & ext_q); // R1
  assign pb_ev   = |(port_b_hi_i ^ pb_q); // R9
  assign t0_rise = t0_pin_i & ~t0p_q;
  assign t0_fall = ~t0_pin_i & t0p_q;
  assign t0_ev   = opt_q[`ISW_OPT_T0CS] ?
                   (opt_q[`ISW_OPT_T0SE] ? t0_fall : t0_rise) : 1'b1;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_q <= 1'b0;
      pb_q  <= 4'h0;
      t0p_q <= 1'b0;
    end else begin
      ext_q <= ext_irq_pin_i;
      pb_q  <= port_b_hi_i;
      t0p_q <= t0_pin_i;
    end
  end

  // shared scaler: ratio 2^(ps+1) for timer, 2^ps for watchdog
  logic       scaler_assignment;
  logic [8:0] m9;
  logic [7:0] mask_t;
  logic [7:0] mask_w;
  logic       t0_inc;
  logic       t0_ovf;
  assign scaler_assignment    = opt_q[`ISW_OPT_PSA]; // R18
  assign m9     = (9'h002 << opt_q[2:0]) - 9'h001;
  assign mask_t = m9[7:0];
  assign mask_w = m9[8:1];
  assign t0_inc = t0_ev & (scaler_assignment | ((scl_q & mask_t) == mask_t));
  assign t0_ovf = t0_inc & (tmr_q == `ISW_TMR_MAX) & ~wr_tmr; // R7

  // watchdog timing
  logic wdt_en;
  logic rc_tick;
  logic wdt_clr;
  logic base_exp;
  logic wdt_to;
  assign wdt_en   = cfg_q[`ISW_CFG_WATCHDOG_FUSE_ENABLE]; // R17
  assign rc_tick  = wdt_en & (rc_q == RW'(RC_DIV - 1)); // R12
  assign wdt_clr  = clr_wdt_i | ~wdt_en |
                    (sleep_i & (pwr_q == isw_pkg::ISW_RUN)); // R19
  assign base_exp = rc_tick & (wdt_q == TW'(WDT_TICKS - 1)) &
                    ~wdt_clr; // R13
  assign wdt_to   = base_exp & (~scaler_assignment | ((scl_q & mask_w) == mask_w));

  // rc tick derived from the core clock; stops when fuse is off
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rc_q <= '0;
    end else if (~wdt_en || rc_tick) begin
      rc_q <= '0;
    end else begin
      rc_q <= rc_q + RW'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wdt_q <= '0;
    end else if (wdt_clr) begin
      wdt_q <= '0; // R19
    end else if (rc_tick) begin
      wdt_q <= (wdt_q == TW'(WDT_TICKS - 1)) ? '0 : wdt_q + TW'(1);
    end
  end

  // assignment bit untouched by clear, only the count goes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_q <= 8'h00;
    end else if (scaler_assignment & wdt_clr) begin
      scl_q <= 8'h00; // R20
    end else if (scaler_assignment ? base_exp : t0_ev) begin
      scl_q <= scl_q + 8'h01; // R18
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tmr_q <= 8'h00;
    end else if (wr_tmr) begin
      tmr_q <= wb_dat_i[7:0];
    end else if (t0_inc) begin
      tmr_q <= tmr_q + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      opt_q <= `ISW_OPT_RST;
      cfg_q <= `ISW_CFG_RST;
    end else begin
      if (wr_opt) begin
        opt_q <= wb_dat_i[7:0];
      end
      if (wr_cfg) begin
        cfg_q <= wb_dat_i[7:0];
      end
    end
  end

  // request and wake-up decisions
  logic pend;
  logic wake_irq;
  logic take;
  logic asleep;
  assign asleep   = (pwr_q == isw_pkg::ISW_SLEEP);
  assign pend     = (icr_q[`ISW_ICR_PORT_CHANGE_FLAG] & icr_q[`ISW_ICR_PORT_CHANGE_IRQ_ENABLE]) |
                    (icr_q[`ISW_ICR_EXT_EDGE_FLAG] & icr_q[`ISW_ICR_EXT_IRQ_ENABLE]) |
                    (icr_q[`ISW_ICR_T0IF] & icr_q[`ISW_ICR_T0IE]);
  assign wake_irq = asleep &
                    ((icr_q[`ISW_ICR_PORT_CHANGE_FLAG] & icr_q[`ISW_ICR_PORT_CHANGE_IRQ_ENABLE]) |
                     (icr_q[`ISW_ICR_T0IF] & icr_q[`ISW_ICR_T0IE]) |
                     (icr_q[`ISW_ICR_EXT_EDGE_FLAG] & icr_q[`ISW_ICR_EXT_IRQ_ENABLE] &
                      ext_irq_enable_slp_q)); // R5
  assign take     = icr_q[`ISW_ICR_GIE] &
                    ((~asleep & pend) | wake_irq); // R6

  // set beats software clear; taking clears global enable
  always_comb begin
    icr_d = wr_icr ? wb_dat_i[7:0] : icr_q; // R4
    icr_d[`ISW_ICR_RSVD] = 1'b0;
    if (ext_ev) begin
      icr_d[`ISW_ICR_EXT_EDGE_FLAG] = 1'b1; // R2 R22
    end
    if (t0_ovf) begin
      icr_d[`ISW_ICR_T0IF] = 1'b1; // R7 R22
    end
    if (pb_ev) begin
      icr_d[`ISW_ICR_PORT_CHANGE_FLAG] = 1'b1; // R9 R22
    end
    if (take) begin
      icr_d[`ISW_ICR_GIE] = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      icr_q <= `ISW_ICR_RST;
    end else begin
      icr_q <= icr_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwr_q      <= isw_pkg::ISW_RUN;
      ext_irq_enable_slp_q <= 1'b0;
    end else begin
      unique case (pwr_q)
        isw_pkg::ISW_RUN: begin
          if (sleep_i) begin
            pwr_q      <= isw_pkg::ISW_SLEEP;
            ext_irq_enable_slp_q <= icr_q[`ISW_ICR_EXT_IRQ_ENABLE]; // R5
          end
        end
        isw_pkg::ISW_SLEEP: begin
          if (wake_irq | wdt_to) begin
            pwr_q <= isw_pkg::ISW_RUN; // R15
          end
        end
      endcase
    end
  end

  // a timeout cannot meet a clear: clear suppresses the expiry
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      to_q <= 1'b1;
    end else if (wdt_to) begin
      to_q <= 1'b0; // R16
    end else if (clr_wdt_i | sleep_i) begin
      to_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_req_o   <= 1'b0;
      wake_o      <= 1'b0;
      wdt_rst_o   <= 1'b0;
      rc_osc_en_o <= 1'b0;
    end else begin
      irq_req_o   <= pend; // R3 R8 R10
      wake_o      <= asleep & (wake_irq | wdt_to); // R15
      wdt_rst_o   <= ~asleep & wdt_to; // R14
      rc_osc_en_o <= wdt_en; // R12
    end
  end

  // only the return pc leaves; w and status stay with software
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      push_o    <= 1'b0;
      push_pc_o <= 13'h0000;
      pc_load_o <= 1'b0;
      pc_vec_o  <= 13'h0000;
    end else begin
      push_o    <= take; // R11
      pc_load_o <= take; // R21
      pc_vec_o  <= `ISW_IRQ_VEC; // R21
      if (take) begin
        push_pc_o <= ret_pc_i; // R11
      end
    end
  end

  a_rise_edge_flag: // R1 R2
  assert property (@(posedge clk_i) disable iff (rst_i)
    ($rose(ext_irq_pin_i) && opt_q[`ISW_OPT_EDGE]) |=>
    icr_q[`ISW_ICR_EXT_EDGE_FLAG])
  else $error("rising edge did not set external flag");

  a_fall_edge_flag: // R1 R2
  assert property (@(posedge clk_i) disable iff (rst_i)
    ($fell(ext_irq_pin_i) && !opt_q[`ISW_OPT_EDGE]) |=>
    icr_q[`ISW_ICR_EXT_EDGE_FLAG])
  else $error("falling edge did not set external flag");

  a_timer_ovf_flag: // R7
  assert property (@(posedge clk_i) disable iff (rst_i)
    (t0_inc && tmr_q == 8'hFF && !wr_tmr) |=>
    (tmr_q == 8'h00 && icr_q[`ISW_ICR_T0IF]))
  else $error("timer rollover missed its flag");

  a_port_change_flag: // R9
  assert property (@(posedge clk_i) disable iff (rst_i)
    (port_b_hi_i != pb_q) |=> icr_q[`ISW_ICR_PORT_CHANGE_FLAG])
  else $error("port change did not set flag");

  a_enables_gate_req: // R3 R8 R10 R22
  assert property (@(posedge clk_i) disable iff (rst_i)
    !(icr_q[3] || icr_q[4] || icr_q[5]) |=> !irq_req_o)
  else $error("request raised with all enables clear");

  a_vector_needs_gie: // R6 R21
  assert property (@(posedge clk_i) disable iff (rst_i)
    pc_load_o |-> ($past(icr_q[`ISW_ICR_GIE]) &&
    !icr_q[`ISW_ICR_GIE] && pc_vec_o == 13'h0004))
  else $error("vector taken without global enable");

  a_push_return_pc: // R11
  assert property (@(posedge clk_i) disable iff (rst_i)
    push_o |-> (pc_load_o && push_pc_o == $past(ret_pc_i)))
  else $error("pushed value is not the return pc");

  a_sleep_ext_block: // R5
  assert property (@(posedge clk_i) disable iff (rst_i)
    (asleep && !ext_irq_enable_slp_q && !wdt_to &&
     !(icr_q[0] && icr_q[3]) && !(icr_q[2] && icr_q[5])) |=> asleep)
  else $error("external edge woke core without prior enable");

  a_wdt_run_reset: // R14 R16
  assert property (@(posedge clk_i) disable iff (rst_i)
    (wdt_to && !asleep) |=> (wdt_rst_o && !to_q && !wake_o))
  else $error("running timeout did not reset");

  a_wdt_sleep_wake: // R15 R16
  assert property (@(posedge clk_i) disable iff (rst_i)
    (wdt_to && asleep) |=> (wake_o && !wdt_rst_o && !asleep && !to_q))
  else $error("sleeping timeout did not wake");

  a_fuse_disables: // R17 R12
  assert property (@(posedge clk_i) disable iff (rst_i)
    !wdt_en |-> (!wdt_to ##1 (!rc_osc_en_o && wdt_q == '0)))
  else $error("watchdog active with fuse cleared");

  a_clear_keeps_psa: // R19 R20
  assert property (@(posedge clk_i) disable iff (rst_i)
    (clr_wdt_i && scaler_assignment && !wr_opt) |=>
    (scl_q == 8'h00 && wdt_q == '0 && opt_q[`ISW_OPT_PSA]))
  else $error("clear did not reset watchdog scaler");

endmodule : isw_irq_wdt

// *** hdl/isw_defs.svh ***
// offsets, field positions, reset values and timing for irq/watchdog
// assumes inclusion by bare name from the design and the bench
`ifndef ISW_DEFS_SVH
`define ISW_DEFS_SVH
`define ISW_IDX_TMR     14'h0001
`define ISW_IDX_STAT    14'h0003
`define ISW_IDX_ICR     14'h000B
`define ISW_IDX_OPT     14'h0081
`define ISW_IDX_CFG     14'h2007
`define ISW_ICR_PORT_CHANGE_FLAG    0
`define ISW_ICR_EXT_EDGE_FLAG    1
`define ISW_ICR_T0IF    2
`define ISW_ICR_PORT_CHANGE_IRQ_ENABLE    3
`define ISW_ICR_EXT_IRQ_ENABLE    4
`define ISW_ICR_T0IE    5
`define ISW_ICR_RSVD    6
`define ISW_ICR_GIE     7
`define ISW_OPT_PSA     3
`define ISW_OPT_T0SE    4
`define ISW_OPT_T0CS    5
`define ISW_OPT_EDGE    6
`define ISW_CFG_WATCHDOG_FUSE_ENABLE   2
`define ISW_STAT_PD     3
`define ISW_STAT_TO     4
`define ISW_ICR_RST     8'h00
`define ISW_OPT_RST     8'hFF
`define ISW_CFG_RST     8'hFF
`define ISW_TMR_MAX     8'hFF
`define ISW_IRQ_VEC     13'h0004
`define ISW_CLK_HZ      125000000
`define ISW_RC_HZ       31250
`define ISW_WDT_MS      16
`endif

// *** hdl/isw_pkg.sv ***
// types shared by the irq/watchdog block
// assumes isw_defs.svh is on the include path
package isw_pkg;
  typedef enum logic {
    ISW_RUN   = 1'b0,
    ISW_SLEEP = 1'b1
  } isw_pwr_t;
endpackage : isw_pkg

// *** verification/isw_core_model.sv ***
// core sequencer and pin model facing the irq/watchdog block
// assumes tb calls its tasks; every change lands just after an edge
module isw_core_model (
  input  wire logic        clk_i,
  output logic             ext_irq_pin_o,
  output logic      [3:0]  port_b_hi_o,
  output logic             t0_pin_o,
  output logic             clr_wdt_o,
  output logic             sleep_o,
  output logic      [12:0] ret_pc_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // pc held still so a pushed value is easy to predict
  initial begin
    ext_irq_pin_o = 1'b0;
    port_b_hi_o   = 4'h0;
    t0_pin_o      = 1'b0;
    clr_wdt_o     = 1'b0;
    sleep_o       = 1'b0;
    ret_pc_o      = 13'h0abc;
  end
  task automatic pin(input logic v);
    @(posedge clk_i);
    ext_irq_pin_o <= v;
  endtask : pin
  task automatic nib(input logic [3:0] v);
    @(posedge clk_i);
    port_b_hi_o <= v;
  endtask : nib
  task automatic t0(input logic v);
    @(posedge clk_i);
    t0_pin_o <= v;
  endtask : t0
  // one-cycle instruction pulses
  task automatic pulse(input logic slp);
    @(posedge clk_i);
    clr_wdt_o <= !slp;
    sleep_o   <= slp;
    @(posedge clk_i);
    clr_wdt_o <= 1'b0;
    sleep_o   <= 1'b0;
  endtask : pulse
endmodule : isw_core_model

// *** verification/tb.sv ***
// self-checking bench for the irq/watchdog block
// assumes small watchdog counts and the core model beside it
`include "isw_defs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RCD = 4;
  localparam int WTK = 5;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [15:0] wb_adr_i = 16'h0000;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o;
  logic        wb_ack_o, ext_irq_pin_i, t0_pin_i, clr_wdt_i, sleep_i;
  logic [3:0]  port_b_hi_i;
  logic [12:0] ret_pc_i, push_pc_o, pc_vec_o, pushed, vec;
  logic        irq_req_o, push_o, pc_load_o, wake_o, wdt_rst_o;
  logic        rc_osc_en_o;
  int          bad_count = 0;
  int          n_compared = 0;
  int          n_rst = 0, n_wake = 0, n_load = 0, t, o, w, l;
  always #4 clk_i = ~clk_i;
  isw_irq_wdt #(.RC_DIV(RCD), .WDT_TICKS(WTK)) isw_irq_wdt_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .ext_irq_pin_i(ext_irq_pin_i),
    .port_b_hi_i(port_b_hi_i), .t0_pin_i(t0_pin_i),
    .clr_wdt_i(clr_wdt_i), .sleep_i(sleep_i), .ret_pc_i(ret_pc_i),
    .irq_req_o(irq_req_o), .push_o(push_o), .push_pc_o(push_pc_o),
    .pc_load_o(pc_load_o), .pc_vec_o(pc_vec_o), .wake_o(wake_o),
    .wdt_rst_o(wdt_rst_o), .rc_osc_en_o(rc_osc_en_o));
  isw_core_model isw_core_model_inst (
    .clk_i(clk_i), .ext_irq_pin_o(ext_irq_pin_i),
    .port_b_hi_o(port_b_hi_i), .t0_pin_o(t0_pin_i),
    .clr_wdt_o(clr_wdt_i), .sleep_o(sleep_i), .ret_pc_o(ret_pc_i));
  // counters move after the edge so tasks never race them
  always @(posedge clk_i) begin
    if (wdt_rst_o === 1'b1) n_rst <= n_rst + 1;
    if (wake_o === 1'b1) n_wake <= n_wake + 1;
    if (pc_load_o === 1'b1) n_load <= n_load + 1;
    if (push_o === 1'b1) begin
      pushed <= push_pc_o;
      vec <= pc_vec_o;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // classic cycle; ack is waited for, never assumed
  task automatic bus(input logic we, input logic [13:0] idx,
                     input logic [7:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= 4'hf;
    wb_dat_i <= {24'h00_0000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 16);
    chk(wb_ack_o, 1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : bus
  task automatic wr(input logic [13:0] idx, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
  endtask : wr
  task automatic rd(input logic [13:0] idx, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, idx, 8'h00, q);
    chk(q, {24'h00_0000, e});
  endtask : rd
  task automatic t_reset;
    rd(`ISW_IDX_ICR, 8'h00);
    rd(`ISW_IDX_OPT, 8'hff);
    rd(`ISW_IDX_CFG, 8'hff);
    rd(`ISW_IDX_STAT, 8'h10);
    rd(14'h0002, 8'h00);
    chk(rc_osc_en_o, 1);
    $display("reset test done");
  endtask : t_reset
  // timer held on its idle pin so its flag stays quiet
  task automatic t_ext;
    wr(`ISW_IDX_OPT, 8'hef);
    isw_core_model_inst.pin(1'b1);
    rd(`ISW_IDX_ICR, 8'h02);
    chk(irq_req_o, 0);
    wr(`ISW_IDX_ICR, 8'h00);
    isw_core_model_inst.pin(1'b0);
    rd(`ISW_IDX_ICR, 8'h00);
    wr(`ISW_IDX_OPT, 8'haf);
    isw_core_model_inst.pin(1'b1);
    rd(`ISW_IDX_ICR, 8'h00);
    isw_core_model_inst.pin(1'b0);
    rd(`ISW_IDX_ICR, 8'h02);
    wr(`ISW_IDX_ICR, 8'h12);
    @(posedge clk_i);
    chk(irq_req_o, 1);
    wr(`ISW_IDX_ICR, 8'h02);
    @(posedge clk_i);
    chk(irq_req_o, 0);
    rd(`ISW_IDX_ICR, 8'h02);
    $display("external pin test done");
  endtask : t_ext
  task automatic t_port;
    wr(`ISW_IDX_ICR, 8'h00);
    isw_core_model_inst.nib(4'h5);
    rd(`ISW_IDX_ICR, 8'h01);
    wr(`ISW_IDX_ICR, 8'h09);
    @(posedge clk_i);
    chk(irq_req_o, 1);
    wr(`ISW_IDX_ICR, 8'h01);
    @(posedge clk_i);
    chk(irq_req_o, 0);
    $display("port change test done");
  endtask : t_port
  task automatic t_timer;
    wr(`ISW_IDX_OPT, 8'hcf);
    wr(`ISW_IDX_ICR, 8'h20);
    wr(`ISW_IDX_TMR, 8'hff);
    repeat (2) @(posedge clk_i);
    rd(`ISW_IDX_ICR, 8'h24);
    chk(irq_req_o, 1);
    l = n_load;
    wr(`ISW_IDX_ICR, 8'ha4);
    repeat (3) @(posedge clk_i);
    chk(n_load, l + 1);
    chk(pushed, 13'h0abc);
    chk(vec, `ISW_IRQ_VEC);
    rd(`ISW_IDX_ICR, 8'h24);
    wr(`ISW_IDX_OPT, 8'he8);
    wr(`ISW_IDX_ICR, 8'h00);
    $display("timer test done");
  endtask : t_timer
  // divider is not cleared, so one rc tick of slack
  task automatic t_wdog;
    isw_core_model_inst.pulse(1'b0);
    @(posedge clk_i);
    t = 1;
    o = n_rst;
    while (n_rst == o && t < 100) begin
      @(posedge clk_i);
      t++;
    end
    chk(t >= RCD * WTK - RCD && t <= RCD * WTK + 3, 1);
    rd(`ISW_IDX_STAT, 8'h00);
    o = n_rst;
    repeat (6) begin
      isw_core_model_inst.pulse(1'b0);
      repeat (8) @(posedge clk_i);
    end
    chk(n_rst, o);
    rd(`ISW_IDX_OPT, 8'he8);
    w = n_wake;
    l = n_load;
    isw_core_model_inst.pulse(1'b1);
    rd(`ISW_IDX_STAT, 8'h18);
    repeat (30) @(posedge clk_i);
    chk(n_wake, w + 1);
    chk(n_rst, o);
    chk(n_load, l);
    rd(`ISW_IDX_STAT, 8'h00);
    $display("watchdog test done");
  endtask : t_wdog
  task automatic t_sleep;
    wr(`ISW_IDX_CFG, 8'hfb);
    repeat (2) @(posedge clk_i);
    chk(rc_osc_en_o, 0);
    o = n_rst;
    isw_core_model_inst.pulse(1'b0);
    repeat (60) @(posedge clk_i);
    chk(n_rst, o);
    w = n_wake;
    l = n_load;
    isw_core_model_inst.pulse(1'b1);
    wr(`ISW_IDX_ICR, 8'h10);
    isw_core_model_inst.pin(1'b1);
    repeat (8) @(posedge clk_i);
    chk(n_wake, w);
    wr(`ISW_IDX_ICR, 8'h08);
    isw_core_model_inst.nib(4'ha);
    repeat (4) @(posedge clk_i);
    chk(n_wake, w + 1);
    chk(n_load, l);
    wr(`ISW_IDX_ICR, 8'h90);
    isw_core_model_inst.pin(1'b0);
    isw_core_model_inst.pulse(1'b1);
    isw_core_model_inst.pin(1'b1);
    repeat (4) @(posedge clk_i);
    chk(n_wake, w + 2);
    chk(n_load, l + 1);
    $display("sleep test done");
  endtask : t_sleep
  // pin-clocked timer, scaler on the timer at 1:2
  task automatic t_pin;
    wr(`ISW_IDX_OPT, 8'he0);
    wr(`ISW_IDX_ICR, 8'h00);
    wr(`ISW_IDX_TMR, 8'hfe);
    repeat (4) begin
      isw_core_model_inst.t0(1'b1);
      isw_core_model_inst.t0(1'b0);
    end
    repeat (2) @(posedge clk_i);
    rd(`ISW_IDX_TMR, 8'h00);
    rd(`ISW_IDX_ICR, 8'h04);
    $display("timer pin test done");
  endtask : t_pin
  task automatic report_and_stop;
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_ext();
    t_port();
    t_timer();
    t_wdog();
    t_sleep();
    t_pin();
    report_and_stop();
  end
  // run needs about 400 cycles; cut off far beyond
  initial begin
    #100000;
    bad_count++;
    report_and_stop();
  end
endmodule : tb
